// ==== design/pcb_window.sv ====
// Peripheral register window decode plus the request wiring between units, fixed for interrupts, selectable for DMA and timer cascade.
// Assumes a single-cycle request strobe from the core bus and that controllers, timers,
// serial and DMA channels live outside and exchange request lines and write notices with this block.
//
// How it works
// - 128 by 16-bit file, word offset decode
// - Base on 256-byte boundary, memory or I/O
// - Pins zero to six feed master controller
// - Pin seven goes only to slave
// - Eleven internal sources: serial, DMA, timer
// - Only serial channel 0 reaches controllers
// - Both serial channels may request DMA
// - DMA from pins, timer 2, serial, software
// - Timer 2 may clock timers 0 and 1
`timescale 1ns/1ns
module pcb_window (
  // Clock and reset
  input  wire logic                              i_clk,
  input  wire logic                              i_sys_rst,
  // Core peripheral bus
  input  wire pcb_pkg::pcb_req_t                 i_bus,
  output pcb_pkg::pcb_rsp_t                      o_bus,
  // Interrupt sources
  input  wire logic [pcb_pkg::EXT_PIN_N-1:0]     i_ext_irq_pin,
  input  wire logic [pcb_pkg::SER_SRC_W-1:0]     i_serial_unit_irq,
  input  wire logic [1:0]                        i_serial_unit1_irq,
  input  wire logic [pcb_pkg::DMA_SRC_N-1:0]     i_dma_irq,
  input  wire logic [pcb_pkg::TMR_SRC_N-1:0]     i_timer_unit_irq,
  input  wire logic                              i_slave_int,
  // Interrupt controller inputs and serial channel 1 requests
  output logic      [7:0]                        o_master_irq,
  output logic      [7:0]                        o_slave_irq,
  output logic      [1:0]                        o_serial_unit1_irq,
  // DMA request wiring
  input  wire logic [pcb_pkg::DMA_CH_N-1:0]      i_dma_request_pin,
  input  wire logic [3:0]                        i_ser_dma_req,
  input  wire logic                              i_timer2_pulse,
  output logic      [pcb_pkg::DMA_CH_N-1:0]      o_dma_req,
  // Timer cascade
  output logic      [1:0]                        o_timer_t2_tick,
  // Write notice to peripherals
  output logic                                   o_periph_wr,
  output logic      [pcb_pkg::IDX_W-1:0]         o_periph_idx,
  output logic      [pcb_pkg::DATA_W-1:0]        o_periph_wdata
);
  import pcb_pkg::*;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  // Word index of a byte offset
  function automatic logic [IDX_W-1:0] idx_of(input logic [7:0] off);
    idx_of = off[7:1];
  endfunction

  // Reserved holes in the window
  function automatic logic is_reserved(input logic [IDX_W-1:0] ix);
    logic [7:0] off;
    off = {ix, 1'b0};
    case (off)
      8'h08, 8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1a, 8'h1c, 8'h1e,
      8'h2c, 8'h2e, 8'h44, 8'h6c, 8'h6e, 8'h7c, 8'h7e, 8'haa, 8'hac,
      8'hae, 8'hba, 8'hdc, 8'hde, 8'hec, 8'hee, 8'hfc, 8'hfe: is_reserved = 1'b1;
      default: is_reserved = 1'b0;
    endcase
  endfunction

  // Read source of the first pipeline stage
  typedef enum { PCB_RD_MEM, PCB_RD_ZERO, PCB_RD_RELOC, PCB_RD_SER, PCB_RD_DMA, PCB_RD_TMR } pcb_rdsel_t;

  // ---------------------------------------------------------------
  // Address match
  // ---------------------------------------------------------------
  logic [DATA_W-1:0]  reloc;        // Window relocation register
  logic               hit;          // Request falls in the window
  logic [IDX_W-1:0]   idx;          // Word index of the request
  logic               wr_hit;       // Write inside the window
  logic               rd_hit;       // Read inside the window

  // Match against the live base and space; a write lands at the edge, so the next access sees it
  assign hit    = i_bus.valid && (i_bus.mem == reloc[RELOC_MEM_BIT]) &&
                  (i_bus.addr[ADDR_W-1:BASE_LSB] == reloc[BASE_W-1:0]);
  assign idx    = i_bus.addr[BASE_LSB-1:1];
  assign wr_hit = hit && i_bus.write && !is_reserved(idx);
  assign rd_hit = hit && !i_bus.write;

  // Relocation register, reset to I/O space
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      reloc <= RELOC_RESET;
    end else if (wr_hit && idx == idx_of(OFF_WINDOW_RELOCATION)) begin
      reloc <= i_bus.wdata & {3'h0, {(BASE_W+1){1'b1}}};
    end
  end

  // ---------------------------------------------------------------
  // Plain storage
  // ---------------------------------------------------------------
  logic               mem_we;       // Store into the register file
  logic [DATA_W-1:0]  mem_rdata;    // Registered file output

  assign mem_we = wr_hit;

  pcb_regmem u_regmem (
    .i_clk   (i_clk),
    .i_we    (mem_we),
    .i_idx   (idx),
    .i_wdata (i_bus.wdata),
    .o_rdata (mem_rdata)
  );

  // ---------------------------------------------------------------
  // Interrupt request latches
  // ---------------------------------------------------------------
  logic [SER_SRC_W-1:0] ser_latch;  // Serial channel 0 requests
  logic [DMA_SRC_N-1:0] dma_latch;  // DMA requests
  logic [TMR_SRC_N-1:0] tmr_latch;  // Timer requests
  logic                 clr_ser;
  logic                 clr_dma;
  logic                 clr_tmr;

  assign clr_ser = wr_hit && idx == idx_of(OFF_SERIAL_IRQ_REQUEST_LATCH);
  assign clr_dma = wr_hit && idx == idx_of(OFF_DMA_IRQ_REQUEST_LATCH);
  assign clr_tmr = wr_hit && idx == idx_of(OFF_TIMER_IRQ_REQUEST_LATCH);

  // Write 1 clears; a request in the same cycle wins so no event is lost
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ser_latch <= '0;
      dma_latch <= '0;
      tmr_latch <= '0;
    end else begin
      ser_latch <= (ser_latch & ~(clr_ser ? i_bus.wdata[SER_SRC_W-1:0] : '0)) | i_serial_unit_irq;
      dma_latch <= (dma_latch & ~(clr_dma ? i_bus.wdata[DMA_SRC_N-1:0] : '0)) | i_dma_irq;
      tmr_latch <= (tmr_latch & ~(clr_tmr ? i_bus.wdata[TMR_SRC_N-1:0] : '0)) | i_timer_unit_irq;
    end
  end

  // ---------------------------------------------------------------
  // Controller input wiring
  // ---------------------------------------------------------------
  // Master: pins 0..6 and the slave cascade; slave: internal sources and pin 7
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_master_irq       <= 8'h00;
      o_slave_irq        <= 8'h00;
      o_serial_unit1_irq <= 2'h0;
    end else begin
      o_master_irq       <= {i_slave_int, i_ext_irq_pin[6:0]};
      o_slave_irq        <= {i_ext_irq_pin[7],
                             |ser_latch[3:2], |ser_latch[1:0],
                             |dma_latch[3:2], |dma_latch[1:0], tmr_latch};
      o_serial_unit1_irq <= i_serial_unit1_irq;
    end
  end

  // ---------------------------------------------------------------
  // DMA request routing
  // ---------------------------------------------------------------
  logic [DMA_SRC_W-1:0] dma_src [DMA_CH_N];  // Source select per channel
  logic [DMA_CH_N-1:0]  dma_sw;              // Software request pulses

  genvar ch;
  generate
    for (ch = 0; ch < DMA_CH_N; ch++) begin : g_dma
      localparam logic [IDX_W-1:0] CTL_IDX = idx_of(OFF_DMA0_CONTROL) + IDX_W'(ch * 8);
      logic ctl_wr;
      assign ctl_wr = wr_hit && idx == CTL_IDX;

      // Source select, default external pin
      always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          dma_src[ch] <= PCB_DSRC_PIN;
          dma_sw[ch]  <= 1'b0;
        end else begin
          if (ctl_wr) begin
            dma_src[ch] <= i_bus.wdata[DMA_SRC_LSB +: DMA_SRC_W];
          end
          dma_sw[ch] <= ctl_wr && i_bus.wdata[DMA_SW_REQ_BIT];
        end
      end

      // Selected request, one registered stage
      always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          o_dma_req[ch] <= 1'b0;
        end else begin
          case (pcb_dma_src_t'(dma_src[ch]))
            PCB_DSRC_PIN:     o_dma_req[ch] <= i_dma_request_pin[ch];
            PCB_DSRC_TIMER2:  o_dma_req[ch] <= i_timer2_pulse;
            PCB_DSRC_SER0_RX: o_dma_req[ch] <= i_ser_dma_req[0];
            PCB_DSRC_SER0_TX: o_dma_req[ch] <= i_ser_dma_req[1];
            PCB_DSRC_SER1_RX: o_dma_req[ch] <= i_ser_dma_req[2];
            PCB_DSRC_SER1_TX: o_dma_req[ch] <= i_ser_dma_req[3];
            PCB_DSRC_SOFT:    o_dma_req[ch] <= dma_sw[ch];
            default:          o_dma_req[ch] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Timer cascade
  // ---------------------------------------------------------------
  logic [1:0] t2_clk_sel;  // Timers 0 and 1 count timer 2 ticks

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      t2_clk_sel <= 2'h0;
    end else begin
      if (wr_hit && idx == idx_of(OFF_TIMER0_CONTROL)) begin
        t2_clk_sel[0] <= i_bus.wdata[TMR_T2CLK_BIT];
      end
      if (wr_hit && idx == idx_of(OFF_TIMER1_CONTROL)) begin
        t2_clk_sel[1] <= i_bus.wdata[TMR_T2CLK_BIT];
      end
    end
  end

  // One-cycle count enable per timer
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_timer_t2_tick <= 2'h0;
    end else begin
      o_timer_t2_tick <= t2_clk_sel & {2{i_timer2_pulse}};
    end
  end

  // ---------------------------------------------------------------
  // Read pipeline
  // ---------------------------------------------------------------
  pcb_rdsel_t         rd_sel;   // Source picked in stage 1
  logic               rd_vld;   // Stage 1 holds a read
  logic [DATA_W-1:0]  rd_hold;  // Flop-side read value

  // Stage 1: pick the source, snapshot the relocation register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_vld  <= 1'b0;
      rd_sel  <= PCB_RD_ZERO;
      rd_hold <= '0;
    end else begin
      rd_vld <= rd_hit;
      if (rd_hit) begin
        if (is_reserved(idx))                                 rd_sel <= PCB_RD_ZERO;
        else if (idx == idx_of(OFF_WINDOW_RELOCATION))        rd_sel <= PCB_RD_RELOC;
        else if (idx == idx_of(OFF_SERIAL_IRQ_REQUEST_LATCH)) rd_sel <= PCB_RD_SER;
        else if (idx == idx_of(OFF_DMA_IRQ_REQUEST_LATCH))    rd_sel <= PCB_RD_DMA;
        else if (idx == idx_of(OFF_TIMER_IRQ_REQUEST_LATCH))  rd_sel <= PCB_RD_TMR;
        else                                                  rd_sel <= PCB_RD_MEM;
        rd_hold <= reloc;
      end
    end
  end

  // Stage 2: answer strobe and data straight from flops
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_bus <= '0;
    end else begin
      o_bus.ack <= rd_vld;
      case (rd_sel)
        PCB_RD_MEM:   o_bus.rdata <= mem_rdata;
        PCB_RD_RELOC: o_bus.rdata <= rd_hold;
        PCB_RD_SER:   o_bus.rdata <= {{(DATA_W-SER_SRC_W){1'b0}}, ser_latch};
        PCB_RD_DMA:   o_bus.rdata <= {{(DATA_W-DMA_SRC_N){1'b0}}, dma_latch};
        PCB_RD_TMR:   o_bus.rdata <= {{(DATA_W-TMR_SRC_N){1'b0}}, tmr_latch};
        default:      o_bus.rdata <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Write notice
  // ---------------------------------------------------------------
  // Peripherals outside see every accepted write one edge later
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_periph_wr    <= 1'b0;
      o_periph_idx   <= '0;
      o_periph_wdata <= '0;
    end else begin
      o_periph_wr <= wr_hit;
      if (wr_hit) begin
        o_periph_idx   <= idx;
        o_periph_wdata <= i_bus.wdata;
      end
    end
  end

endmodule // pcb_window

// ==== design/pcb_pkg.sv ====
// Shared constants and types for the peripheral register window.
// Assumes a 20-bit core address, a 16-bit internal data path and byte offsets inside the window.
package pcb_pkg;

  // ---------------------------------------------------------------
  // Window geometry
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W     = 20;      // Core address width
  localparam int unsigned DATA_W     = 16;      // Register width
  localparam int unsigned IDX_W      = 7;       // Word index width (128 words)
  localparam int unsigned WORDS      = 128;     // Register file depth
  localparam int unsigned BASE_W     = 12;      // Base field: address bits 19:8
  localparam int unsigned BASE_LSB   = 8;       // 256-byte alignment

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_MASTER_IRQ_CTRL_PORT_A = 8'h00;
  localparam logic [7:0] OFF_MASTER_IRQ_CTRL_PORT_B = 8'h02;
  localparam logic [7:0] OFF_SLAVE_IRQ_CTRL_PORT_A  = 8'h04;
  localparam logic [7:0] OFF_SLAVE_IRQ_CTRL_PORT_B  = 8'h06;
  localparam logic [7:0] OFF_SERIAL_IRQ_REQUEST_LATCH = 8'h0a;
  localparam logic [7:0] OFF_DMA_IRQ_REQUEST_LATCH  = 8'h0c;
  localparam logic [7:0] OFF_TIMER_IRQ_REQUEST_LATCH = 8'h0e;
  localparam logic [7:0] OFF_TIMER0_CONTROL         = 8'h36;
  localparam logic [7:0] OFF_TIMER1_CONTROL         = 8'h3e;
  localparam logic [7:0] OFF_WINDOW_RELOCATION      = 8'ha8;
  localparam logic [7:0] OFF_DMA0_CONTROL           = 8'hca;
  localparam logic [7:0] OFF_DMA1_CONTROL           = 8'hda;
  localparam logic [7:0] OFF_DMA2_CONTROL           = 8'hea;
  localparam logic [7:0] OFF_DMA3_CONTROL           = 8'hfa;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned RELOC_MEM_BIT     = 12;        // 1 = memory space, 0 = I/O space
  localparam logic [15:0] RELOC_RESET       = 16'h00ff;  // I/O space, base 0xff00
  localparam int unsigned TMR_T2CLK_BIT     = 3;         // Timer clocked by timer 2
  localparam int unsigned DMA_SRC_LSB       = 0;         // DMA request source select
  localparam int unsigned DMA_SRC_W         = 3;
  localparam int unsigned DMA_SW_REQ_BIT    = 3;         // Write 1: software request pulse
  localparam int unsigned SER_SRC_W         = 4;         // Serial interrupt sources
  localparam int unsigned DMA_SRC_N         = 4;         // DMA interrupt sources
  localparam int unsigned TMR_SRC_N         = 3;         // Timer interrupt sources
  localparam int unsigned DMA_CH_N          = 4;         // DMA channels
  localparam int unsigned EXT_PIN_N         = 8;         // External interrupt pins
  localparam int unsigned READ_LATENCY      = 2;         // Request edge to answer

  // DMA request source codes
  typedef enum logic [2:0] {
    PCB_DSRC_PIN, PCB_DSRC_TIMER2, PCB_DSRC_SER0_RX, PCB_DSRC_SER0_TX,
    PCB_DSRC_SER1_RX, PCB_DSRC_SER1_TX, PCB_DSRC_SOFT, PCB_DSRC_NONE
  } pcb_dma_src_t;

  // One internal bus request
  typedef struct packed {
    logic              valid;  // Request present this cycle
    logic              write;  // 1 = write, 0 = read
    logic              mem;    // 1 = memory space, 0 = I/O space
    logic [ADDR_W-1:0] addr;   // Byte address
    logic [DATA_W-1:0] wdata;  // Write data
  } pcb_req_t;

  // Answer to a request
  typedef struct packed {
    logic              ack;    // One-cycle answer
    logic [DATA_W-1:0] rdata;  // Read data
  } pcb_rsp_t;

endpackage : pcb_pkg

// ==== design/pcb_regmem.sv ====
// Word-addressed storage for the plain read/write part of the register window.
// Assumes one access per cycle; read data come out of a register one edge later.
`timescale 1ns/1ns
module pcb_regmem (
  // Clock
  input  wire logic                        i_clk,
  // Access
  input  wire logic                        i_we,
  input  wire logic [pcb_pkg::IDX_W-1:0]   i_idx,
  input  wire logic [pcb_pkg::DATA_W-1:0]  i_wdata,
  output logic      [pcb_pkg::DATA_W-1:0]  o_rdata
);
  import pcb_pkg::*;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] mem [WORDS];  // No reset: contents are software's

  // Write port
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_idx] <= i_wdata;
    end
  end

  // Registered read, old data on a same-cycle write
  always_ff @(posedge i_clk) begin
    o_rdata <= mem[i_idx];
  end

endmodule // pcb_regmem

// ==== bench/pcb_window_sva.sv ====
// Checker for the register window: bus answers, write notices and request routing.
// Assumes it is bound into pcb_window and sees only that module's ports.
`timescale 1ns/1ns
module pcb_window_sva (
  // Clock and reset
  input wire logic              i_clk,
  input wire logic              i_sys_rst,
  // Core bus
  input wire pcb_pkg::pcb_req_t i_bus,
  input wire pcb_pkg::pcb_rsp_t o_bus,
  // Request wiring
  input wire logic [7:0]        i_ext_irq_pin,
  input wire logic              i_slave_int,
  input wire logic [1:0]        i_serial_unit1_irq,
  input wire logic [3:0]        i_dma_request_pin,
  input wire logic [3:0]        i_ser_dma_req,
  input wire logic              i_timer2_pulse,
  input wire logic [7:0]        o_master_irq,
  input wire logic [7:0]        o_slave_irq,
  input wire logic [1:0]        o_serial_unit1_irq,
  input wire logic [3:0]        o_dma_req,
  input wire logic [1:0]        o_timer_t2_tick,
  input wire logic              o_periph_wr,
  input wire logic [15:0]       o_periph_wdata
);
  import pcb_pkg::*;
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  logic [1:0] up; // Edges since release; $past is void before this
  logic [2:0] wq; // Recent write requests, software DMA may follow
  // Count edges after reset release
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) up <= 2'h0;
    else up <= {up[0], 1'b1};
  end
  // Remember write requests of the last three edges
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) wq <= 3'h0;
    else wq <= {wq[1:0], i_bus.valid & i_bus.write};
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  AST_MASTER_PINS: assert property (up[0] |-> o_master_irq == $past({i_slave_int, i_ext_irq_pin[6:0]}))
    else $error("master inputs do not follow pins");
  AST_SLAVE_PIN7: assert property (up[0] |-> o_slave_irq[7] == $past(i_ext_irq_pin[7]))
    else $error("pin seven not at slave");
  AST_SER1_OUT: assert property (up[0] |-> o_serial_unit1_irq == $past(i_serial_unit1_irq))
    else $error("serial channel 1 requests not passed out");
  AST_ACK_CAUSE: assert property (o_bus.ack |-> $past(i_bus.valid && !i_bus.write, 2))
    else $error("answer without read two cycles before");
  AST_WR_NOACK: assert property (i_bus.valid && i_bus.write |-> ##2 !o_bus.ack)
    else $error("write answered");
  AST_RSVD_ZERO: assert property (o_bus.ack && $past(i_bus.addr[7:1], 2) == 7'h04 |-> o_bus.rdata == 16'h0)
    else $error("reserved word not read as zero");
  AST_PERIPH_WR: assert property (o_periph_wr |-> $past(i_bus.valid && i_bus.write)
    && o_periph_wdata == $past(i_bus.wdata) && $past(i_bus.addr[7:1]) != 7'h04)
    else $error("write notice without matching write");
  AST_TICK: assert property (|o_timer_t2_tick |-> $past(i_timer2_pulse))
    else $error("timer tick without timer 2 pulse");
  AST_DMA_CAUSE: assert property (|o_dma_req |-> (|wq) ||
    $past(|i_dma_request_pin || i_timer2_pulse || |i_ser_dma_req))
    else $error("dma request without source");
  // Main scenarios reached
  cover property (o_bus.ack);
  cover property (o_periph_wr);
  cover property (|o_dma_req);
  cover property (&o_timer_t2_tick);
endmodule // pcb_window_sva

bind pcb_window pcb_window_sva i_pcb_window_sva (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus(i_bus),
  .o_bus(o_bus), .i_ext_irq_pin(i_ext_irq_pin), .i_slave_int(i_slave_int),
  .i_serial_unit1_irq(i_serial_unit1_irq), .i_dma_request_pin(i_dma_request_pin),
  .i_ser_dma_req(i_ser_dma_req), .i_timer2_pulse(i_timer2_pulse), .o_master_irq(o_master_irq),
  .o_slave_irq(o_slave_irq), .o_serial_unit1_irq(o_serial_unit1_irq), .o_dma_req(o_dma_req),
  .o_timer_t2_tick(o_timer_t2_tick), .o_periph_wr(o_periph_wr), .o_periph_wdata(o_periph_wdata));

// ==== bench/pcb_core_model.sv ====
// Core side of the internal peripheral bus: one-cycle requests, two-cycle read answers.
// Assumes each task is entered right after a rising edge of i_clk.
`timescale 1ns/1ns
module pcb_core_model (
  // Clock
  input  wire logic              i_clk,
  // Bus
  input  wire pcb_pkg::pcb_rsp_t i_rsp,
  output pcb_pkg::pcb_req_t      o_req
);
  import pcb_pkg::*;
  initial o_req = '0;
  // Present a request; it is taken at the next rising edge
  task automatic put(input logic w, input logic m, input logic [19:0] a, input logic [15:0] d);
    o_req <= '{valid: 1'b1, write: w, mem: m, addr: a, wdata: d};
    @(posedge i_clk);
  endtask
  // Release: lines turn over so a stale address never looks valid
  task automatic drop();
    o_req <= '{valid: 1'b0, write: 1'b0, mem: ~o_req.mem, addr: ~o_req.addr, wdata: ~o_req.wdata};
  endtask
  // Write; keep=1 lets the next request follow back to back
  task automatic wr(input logic m, input logic [19:0] a, input logic [15:0] d, input logic keep);
    put(1'b1, m, a, d);
    if (!keep) drop();
  endtask
  // Read, taking data at the edge where the answer is seen
  task automatic rd(input logic m, input logic [19:0] a, output logic [15:0] q, output logic ok);
    ok = 1'b0;
    q = 16'h0;
    put(1'b0, m, a, 16'h0);
    drop();
    repeat (3) begin
      @(posedge i_clk);
      if (i_rsp.ack === 1'b1) begin
        q = i_rsp.rdata;
        ok = 1'b1;
      end
    end
  endtask
endmodule // pcb_core_model

// ==== bench/pcb_window_tb_top.sv ====
// Testbench for the register window: bus accesses, relocation and request wiring.
// Assumes the core model and the bound checker; all inputs change by NBA at rising edges.
`timescale 1ns/1ns
module pcb_window_tb_top;
  import pcb_pkg::*;
  localparam logic [19:0] IOB = 20'h0ff00; // Window base after reset, I/O space
  logic       clk   = 1'b0;
  logic       rst   = 1'b1;
  pcb_req_t   bus;
  pcb_rsp_t   rsp;
  logic [7:0] pins  = 8'h0;
  logic [3:0] ser   = 4'h0;
  logic [1:0] ser1  = 2'h0;
  logic [3:0] dirq  = 4'h0;
  logic [2:0] tmr   = 3'h0;
  logic       sint  = 1'b0;
  logic [3:0] dpin  = 4'h0;
  logic [3:0] sdreq = 4'h0;
  logic       t2    = 1'b0;
  logic [7:0] mirq, sirq;
  logic [3:0] dreq;
  logic [1:0] s1o, tick;
  logic       pwr;   // Write notice strobe
  logic [6:0] pidx;  // Write notice word index
  logic [15:0] pwd;  // Write notice data
  int         n_fail, check_count, cyc;
  always #5 clk = ~clk;
  pcb_core_model i_pcb_core_model (.i_clk(clk), .i_rsp(rsp), .o_req(bus));
  pcb_window i_pcb_window (.i_clk(clk), .i_sys_rst(rst), .i_bus(bus), .o_bus(rsp), .i_ext_irq_pin(pins),
    .i_serial_unit_irq(ser), .i_serial_unit1_irq(ser1), .i_dma_irq(dirq), .i_timer_unit_irq(tmr),
    .i_slave_int(sint), .o_master_irq(mirq), .o_slave_irq(sirq), .o_serial_unit1_irq(s1o),
    .i_dma_request_pin(dpin), .i_ser_dma_req(sdreq), .i_timer2_pulse(t2), .o_dma_req(dreq),
    .o_timer_t2_tick(tick), .o_periph_wr(pwr), .o_periph_idx(pidx), .o_periph_wdata(pwd));
  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Read and compare answer presence and data
  task automatic rdc(input logic m, input logic [19:0] a, input logic [15:0] e, input logic eok);
    logic [15:0] q;
    logic        ok;
    i_pcb_core_model.rd(m, a, q, ok);
    chk("answer", {15'h0, eok}, {15'h0, ok});
    if (eok) chk("read data", e, q);
  endtask
  // Drive DMA sources {ser dma[3:0], timer2, pin0}
  task automatic drv(input logic [5:0] v);
    @(posedge clk);
    dpin[0] <= v[0];
    t2 <= v[1];
    sdreq <= v[5:2];
  endtask
  // Collect ticks and DMA requests over four cycles
  task automatic watch(output logic [5:0] s);
    s = 6'h0;
    repeat (4) begin
      @(posedge clk);
      #1;
      s |= {tick, dreq};
    end
  endtask
  // Cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    logic [5:0] s;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(0, IOB | 20'ha8, 16'h00ff, 1);
    rdc(1, IOB | 20'ha8, 16'h0, 0);
    i_pcb_core_model.wr(0, IOB | 20'h04, 16'ha5c3, 1);
    rdc(0, IOB | 20'h04, 16'ha5c3, 1);
    i_pcb_core_model.wr(0, 20'h0fe04, 16'hffff, 1);
    rdc(0, IOB | 20'h05, 16'ha5c3, 1);
    i_pcb_core_model.wr(0, IOB | 20'h08, 16'h1234, 1);
    rdc(0, IOB | 20'h08, 16'h0, 1);
    // Pin routing, two opposite patterns
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      pins <= k ? 8'haa : 8'h55;
      sint <= !k;
      ser1 <= k ? 2'h1 : 2'h2;
      @(posedge clk);
      #1;
      chk("master inputs", k ? 16'h2a : 16'hd5, {8'h0, mirq});
      chk("slave inputs", k ? 16'h80 : 16'h0, {8'h0, sirq});
      chk("serial 1 out", k ? 16'h1 : 16'h2, {14'h0, s1o});
    end
    // Internal sources latched and cleared
    @(posedge clk);
    pins <= 8'h0;
    ser <= 4'h2;
    dirq <= 4'h8;
    tmr <= 3'h4;
    @(posedge clk);
    ser <= 4'h0;
    dirq <= 4'h0;
    tmr <= 3'h0;
    rdc(0, IOB | 20'h0a, 16'h0002, 1);
    rdc(0, IOB | 20'h0c, 16'h0008, 1);
    rdc(0, IOB | 20'h0e, 16'h0004, 1);
    #1;
    chk("slave latched", 16'h34, {8'h0, sirq});
    @(posedge clk);
    i_pcb_core_model.wr(0, IOB | 20'h0a, 16'hffff, 1);
    i_pcb_core_model.wr(0, IOB | 20'h0c, 16'hffff, 1);
    i_pcb_core_model.wr(0, IOB | 20'h0e, 16'hffff, 1);
    rdc(0, IOB | 20'h0a, 16'h0, 1);
    #1;
    chk("slave cleared", 16'h0, {8'h0, sirq});
    // Every DMA source code on channel 0: others quiet, selected one passes
    for (int c = 0; c < 8; c++) begin
      @(posedge clk);
      i_pcb_core_model.wr(0, IOB | 20'hca, 16'(c), 0);
      drv((c < 6) ? ~(6'h1 << c) : 6'h3f);
      watch(s);
      chk("dma unselected", 16'h0, {12'h0, s[3:0]});
      drv(6'h0);
      if (c == 6) i_pcb_core_model.wr(0, IOB | 20'hca, 16'h000e, 0);
      else if (c < 6) drv(6'h1 << c);
      watch(s);
      chk("dma selected", {15'h0, c != 7}, {12'h0, s[3:0]});
      drv(6'h0);
    end
    // Timer 2 cascades into timers 0 then 1
    for (int t = 0; t < 2; t++) begin
      drv(6'h0);
      i_pcb_core_model.wr(0, IOB | (t ? 20'h3e : 20'h36), 16'h0008, 0);
      drv(6'h02);
      watch(s);
      chk("timer ticks", t ? 16'h3 : 16'h1, {14'h0, s[5:4]});
    end
    // Relocation to memory space, used by the very next access
    drv(6'h0);
    i_pcb_core_model.wr(0, IOB | 20'ha8, 16'hf020, 1);
    rdc(1, 20'h020a8, 16'h1020, 1);
    rdc(0, IOB | 20'ha8, 16'h0, 0);
    rdc(1, 20'h02004, 16'ha5c3, 1);
    // Write notice still holds the relocation write, the last one accepted
    chk("notice index", 16'h0054, {9'h0, pidx});
    chk("notice data", 16'hf020, pwd);
    chk("notice strobe", 16'h0, {15'h0, pwr});
    conclude();
  end
endmodule // pcb_window_tb_top
